/* hw/conv_seq_pkg.sv */
// shared constants and types for the conversion clock and state sequencer
package conv_seq_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 10;

  // conversion length in conversion clock ticks, and internal tick rate
  localparam logic [15:0] CONV_TICKS = 16'hA04C;
  localparam int CONV_INT_NS = 147000000;
  localparam int INT_TICK_CYC = CONV_INT_NS / (CLK_PERIOD_NS * 41036);

  // serial output word
  localparam int RESULT_W = 17;
  localparam int WORD_W = 24;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [3:0] PAD_BITS = 4'h0;

  // internally generated serial clock
  localparam int DOUT_INT_NS = 620000;
  localparam int SCK_HALF_INT_CYC = DOUT_INT_NS / (CLK_PERIOD_NS * 24 * 2);
  localparam logic [10:0] SCK_HALF_EXT_TICKS = 11'h004;

  // power-on reset and clock-presence window
  localparam int POR_NS = 4000000;
  localparam int POR_CYC_DEF = POR_NS / CLK_PERIOD_NS;
  localparam int DET_MIN_HZ = 10000;
  localparam int DET_WINDOW_NS = 150000;
  localparam int DET_CYC_DEF = DET_WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [1:0] DET_EDGES_NEEDED = 2'h2;

  // calibration slot at the start of each conversion
  localparam logic [15:0] CAL_TICKS = 16'h0400;

  // counter widths
  localparam int POR_W = 19;
  localparam int DET_W = 14;
  localparam int DIV_W = 11;

  // sequencer states, gray along por, convert, sleep, data out
  typedef enum logic [1:0] {
    ST_POR = 2'h2,
    ST_CONVERT = 2'h0,
    ST_SLEEP = 2'h1,
    ST_DOUT = 2'h3
  } seq_state_t;

  typedef enum logic {
    SCK_EXTERNAL = 1'b0,
    SCK_INTERNAL = 1'b1
  } sck_mode_t;

  // pins arriving from outside the core clock domain
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic rej;
  } pin_in_t;

  localparam pin_in_t PIN_IDLE = 3'h6;

  // serial pin drive
  typedef struct packed {
    logic sdo;
    logic sdo_oe_n;
    logic sck;
    logic sck_oe_n;
  } serial_out_t;

  // sequencer status toward the analog core
  typedef struct packed {
    seq_state_t state;
    logic osc_en;
    logic ext_sel;
    logic por_active;
    logic cal_active;
    logic suspect;
    logic conv_start;
  } seq_status_t;

endpackage

/* hw/conv_sequencer.sv */
// conversion clock selection, state timing and power-on sequencing
// Operation
// - toggling rejection pin selects external clock, oscillator off
// - no external clock means internal oscillator mode
// - source change in sleep or external readout harmless
// - mid-conversion change spoils only that one result
// - internal serial clock keeps valid data across change
// - internal clock conversion lasts 147 ms
// - sleep persists while chip select stays high
// - internal readout at most 24 cycles, 0.62 ms
// - calibration inside each conversion, timing unchanged
// - exactly one output word per conversion
// - power-on reset lasts about 4 ms
// - power-on reset clears every register and mode
// - after power-on reset convert, sleep, output in order
// - static rejection pin level selects internal oscillator
// - external serial clock: sleep until first rising serial edge, select low
// - 24th falling serial edge starts new conversion
// - select rising during readout aborts, starts conversion
`timescale 1ns/1ps
module conv_sequencer #(
  parameter logic [15:0] CONV_LEN = conv_seq_pkg::CONV_TICKS,
  parameter logic [conv_seq_pkg::POR_W-1:0] POR_CYC =
    conv_seq_pkg::POR_W'(conv_seq_pkg::POR_CYC_DEF),
  parameter logic [conv_seq_pkg::DET_W-1:0] DET_CYC =
    conv_seq_pkg::DET_W'(conv_seq_pkg::DET_CYC_DEF)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input conv_seq_pkg::pin_in_t pins_i,
  input wire logic [conv_seq_pkg::RESULT_W-1:0] conv_result_i,
  output conv_seq_pkg::serial_out_t serial_o,
  output conv_seq_pkg::seq_status_t status_o
);
  import conv_seq_pkg::*;

  typedef struct packed {
    pin_in_t s1;
    pin_in_t s2;
    pin_in_t s3;
    seq_state_t state;
    sck_mode_t mode;
    logic ext_sel;
    logic osc_en;
    logic [1:0] det_edges;
    logic [DET_W-1:0] det_cnt;
    logic [DIV_W-1:0] tick_div;
    logic [15:0] conv_cnt;
    logic [DIV_W-1:0] sck_div;
    logic [4:0] bit_cnt;
    logic [WORD_W-1:0] shreg;
    logic [POR_W-1:0] por_cnt;
    logic por_active;
    logic cal;
    logic suspect;
    logic conv_start;
    logic sdo;
    logic sdo_oe_n;
    logic sck;
    logic sck_oe_n;
  } seq_regs_t;

  localparam seq_regs_t REGS_RESET = '{
    s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE,
    state: ST_POR, mode: SCK_EXTERNAL,
    ext_sel: 1'b0, osc_en: 1'b1, det_edges: 2'h0,
    det_cnt: '0, tick_div: '0, conv_cnt: 16'h0000, sck_div: '0,
    bit_cnt: 5'h00, shreg: '0, por_cnt: '0, por_active: 1'b1,
    cal: 1'b0, suspect: 1'b0, conv_start: 1'b0,
    sdo: 1'b1, sdo_oe_n: 1'b1, sck: 1'b0, sck_oe_n: 1'b1
  };

  seq_regs_t st_reg;
  seq_regs_t st_next;

  // edges seen on the synchronised pins; stage one is never read here
  logic rej_rise;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic conv_tick;
  logic src_change;
  logic conv_last;
  logic int_sck_edge;

  assign rej_rise = st_reg.s2.rej & ~st_reg.s3.rej;
  assign cs_fall = ~st_reg.s2.cs_n & st_reg.s3.cs_n;
  assign cs_rise = st_reg.s2.cs_n & ~st_reg.s3.cs_n;
  assign sck_rise = st_reg.s2.sck & ~st_reg.s3.sck;
  assign sck_fall = ~st_reg.s2.sck & st_reg.s3.sck;

  // one conversion clock tick: external edge or divided core clock
  assign conv_tick = st_reg.ext_sel ? rej_rise :
    (st_reg.tick_div == DIV_W'(INT_TICK_CYC - 1));
  assign src_change = st_next.ext_sel != st_reg.ext_sel;
  assign conv_last = conv_tick && (st_reg.conv_cnt == CONV_LEN - 16'h0001);

  // internal serial clock half period; >= so a source swap never overruns
  assign int_sck_edge = st_reg.ext_sel ?
    (conv_tick && st_reg.sck_div >= SCK_HALF_EXT_TICKS - 11'h001) :
    (st_reg.sck_div >= DIV_W'(SCK_HALF_INT_CYC - 1));

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.conv_start = 1'b0;

    // presence detector: two edges, each inside the window, mean a clock
    if (rej_rise) begin
      st_next.det_cnt = '0;
      if (st_reg.det_edges != DET_EDGES_NEEDED) begin
        st_next.det_edges = st_reg.det_edges + 2'h1;
      end
    end else if (st_reg.det_cnt >= DET_CYC) begin
      st_next.det_edges = 2'h0;
    end else begin
      st_next.det_cnt = st_reg.det_cnt + DET_W'(1);
    end
    st_next.ext_sel = (st_next.det_edges == DET_EDGES_NEEDED);
    st_next.osc_en = ~st_next.ext_sel;

    // internal tick divider runs only while the oscillator is in use
    if (st_reg.ext_sel || conv_tick) begin
      st_next.tick_div = '0;
    end else begin
      st_next.tick_div = st_reg.tick_div + DIV_W'(1);
    end

    // serial mode is chosen by the serial clock level at select fall
    if (cs_fall) begin
      st_next.mode = st_reg.s2.sck ? SCK_INTERNAL : SCK_EXTERNAL;
    end

    case (st_reg.state)
      ST_POR: begin
        st_next.por_cnt = st_reg.por_cnt + POR_W'(1);
        if (st_reg.por_cnt == POR_CYC - POR_W'(1)) begin
          st_next.state = ST_CONVERT;
          st_next.por_active = 1'b0;
          st_next.conv_start = 1'b1;
          st_next.conv_cnt = 16'h0000;
          st_next.mode = st_reg.s2.sck ? SCK_INTERNAL : SCK_EXTERNAL;
        end
      end
      ST_CONVERT: begin
        // a swap mid-conversion flags only this word; count restarts next
        if (src_change) begin
          st_next.suspect = 1'b1;
        end
        if (conv_last) begin
          st_next.state = ST_SLEEP;
          st_next.shreg = {3'b000, conv_result_i, PAD_BITS};
          st_next.cal = 1'b0;
        end else if (conv_tick) begin
          st_next.conv_cnt = st_reg.conv_cnt + 16'h0001;
          // calibration rides inside the fixed tick count
          st_next.cal = (st_next.conv_cnt < CAL_TICKS);
        end
      end
      ST_SLEEP: begin
        // a source change here is harmless: nothing is being timed
        if (!st_reg.s2.cs_n) begin
          if (st_next.mode == SCK_INTERNAL) begin
            st_next.state = ST_DOUT;
            st_next.sck_div = '0;
            st_next.bit_cnt = 5'h00;
          end else if (sck_rise) begin
            st_next.state = ST_DOUT;
            st_next.bit_cnt = 5'h00;
          end
        end
      end
      ST_DOUT: begin
        if (cs_rise) begin
          st_next.state = ST_CONVERT;
        end else if (st_reg.mode == SCK_EXTERNAL) begin
          if (sck_fall) begin
            st_next.shreg = {st_reg.shreg[WORD_W-2:0], 1'b1};
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == LAST_BIT) begin
              st_next.state = ST_CONVERT;
            end
          end
        end else begin
          if (st_reg.ext_sel ? conv_tick : 1'b1) begin
            st_next.sck_div = st_reg.sck_div + DIV_W'(1);
          end
          if (int_sck_edge) begin
            st_next.sck_div = '0;
            st_next.sck = ~st_reg.sck;
            if (st_reg.sck) begin
              st_next.shreg = {st_reg.shreg[WORD_W-2:0], 1'b1};
              st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
              if (st_reg.bit_cnt == LAST_BIT) begin
                st_next.state = ST_CONVERT;
              end
            end
          end
        end
        if (st_next.state == ST_CONVERT) begin
          st_next.conv_start = 1'b1;
          st_next.conv_cnt = 16'h0000;
          st_next.suspect = 1'b0;
          st_next.sck = 1'b0;
          st_next.bit_cnt = 5'h00;
        end
      end
      default: begin
        st_next.state = ST_POR;
      end
    endcase

    // pin drive: data hidden while deselected, eoc high while converting
    st_next.sdo_oe_n = st_reg.s2.cs_n;
    st_next.sdo = (st_next.state == ST_CONVERT || st_next.state == ST_POR) ?
      1'b1 : st_next.shreg[WORD_W-1];
    st_next.sck_oe_n = ~(st_next.mode == SCK_INTERNAL && !st_reg.s2.cs_n &&
      st_next.state != ST_POR);
  end

  // power-valid reset clears every field to a constant
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= REGS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_o = '{sdo: st_reg.sdo, sdo_oe_n: st_reg.sdo_oe_n,
    sck: st_reg.sck, sck_oe_n: st_reg.sck_oe_n};
  assign status_o = '{state: st_reg.state, osc_en: st_reg.osc_en,
    ext_sel: st_reg.ext_sel, por_active: st_reg.por_active,
    cal_active: st_reg.cal, suspect: st_reg.suspect,
    conv_start: st_reg.conv_start};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_osc_off_ext: assert property (
    st_reg.ext_sel |-> !st_reg.osc_en)
    else $error("oscillator left on with external clock");
  a_static_pin_int: assert property (
    (!rej_rise && st_reg.det_cnt >= DET_CYC) |=> !st_reg.ext_sel ##0
      st_reg.osc_en)
    else $error("external clock kept without edges");
  a_conv_length: assert property (
    (st_reg.state == ST_CONVERT && conv_last) |=> st_reg.state == ST_SLEEP)
    else $error("conversion did not end on last tick");
  a_conv_early: assert property (
    (st_reg.state == ST_CONVERT && !conv_last) |=>
      st_reg.state == ST_CONVERT)
    else $error("conversion ended before tick count");
  a_sleep_hold: assert property (
    (st_reg.state == ST_SLEEP && st_reg.s2.cs_n) |=>
      st_reg.state == ST_SLEEP)
    else $error("sleep left while select high");
  a_wait_rise: assert property (
    (st_reg.state == ST_SLEEP && st_reg.mode == SCK_EXTERNAL &&
      !sck_rise && !cs_fall) |=> st_reg.state == ST_SLEEP)
    else $error("readout began without serial rising edge");
  a_bit_bound: assert property (
    st_reg.state == ST_DOUT |-> st_reg.bit_cnt < 5'h18)
    else $error("readout longer than 24 bits");
  a_last_fall: assert property (
    (st_reg.state == ST_DOUT && st_reg.mode == SCK_EXTERNAL && !cs_rise &&
      sck_fall && st_reg.bit_cnt == LAST_BIT) |=>
      st_reg.state == ST_CONVERT && st_reg.conv_start)
    else $error("24th falling edge did not start conversion");
  a_abort_read: assert property (
    (st_reg.state == ST_DOUT && cs_rise) |=>
      st_reg.state == ST_CONVERT && st_reg.conv_start && st_reg.sdo)
    else $error("select rise did not abort readout");
  a_por_hold: assert property (
    (st_reg.state == ST_POR && st_reg.por_cnt < POR_CYC - POR_W'(1)) |=>
      st_reg.por_active && st_reg.state == ST_POR)
    else $error("power-on reset ended early");
  a_por_exit: assert property (
    $fell(st_reg.por_active) |-> st_reg.state == ST_CONVERT &&
      st_reg.conv_start && st_reg.conv_cnt == 16'h0000)
    else $error("power-on reset not followed by conversion");
  a_cal_inside: assert property (
    st_reg.cal |-> st_reg.state == ST_CONVERT)
    else $error("calibration outside conversion");
  a_one_word: assert property (
    (st_reg.state == ST_SLEEP && $past(st_reg.state) == ST_CONVERT) |->
      st_reg.shreg[WORD_W-1:WORD_W-2] == 2'b00 && st_reg.shreg[3:0] == 4'h0)
    else $error("output word not loaded at conversion end");
  a_swap_flag: assert property (
    (st_reg.state == ST_CONVERT && src_change) |=> st_reg.suspect)
    else $error("source change mid-conversion not flagged");

endmodule // conv_sequencer

/* dv/host_model.sv */
// host controller model driving select, serial clock and rejection pin
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk_i,
  input conv_seq_pkg::serial_out_t serial_i,
  output conv_seq_pkg::pin_in_t pins_o
);
  import conv_seq_pkg::*;
  logic cs_n = 1'b1;
  logic sck_drv = 1'b0;
  logic rej_on = 1'b0;
  logic rej_lvl = 1'b0;
  logic rej = 1'b0;
  logic [1:0] ph = 2'h0;

  // the sck wire follows the device while it drives, else the host level
  assign pins_o = '{cs_n: cs_n,
    sck: serial_i.sck_oe_n ? sck_drv : serial_i.sck, rej: rej};

  // 25 MHz conversion clock, far above the detection floor
  always @(posedge core_clk_i) begin
    ph <= ph + 2'h1;
    rej <= #1 rej_on ? ph[1] : rej_lvl;
  end

  // select changes just after a core edge
  task automatic set_cs(input logic v);
    @(posedge core_clk_i);
    #1 cs_n = v;
  endtask

  // serial clock runs only inside the frame; data latched on each rise
  task automatic read_bits(input int n, output logic [31:0] w);
    w = 32'h0;
    for (int i = 0; i < n; i++) begin
      #62.5 sck_drv = 1'b1;
      w = {w[30:0], serial_i.sdo};
      #62.5 sck_drv = 1'b0;
    end
  endtask

  // device drives the serial clock; latch data just after each rise
  task automatic read_int(output logic [31:0] w);
    w = 32'h0;
    repeat (24) begin
      @(posedge serial_i.sck);
      #2 w = {w[30:0], serial_i.sdo};
    end
  endtask
endmodule // host_model

/* dv/conversion_clock_state_sequencer_tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module conversion_clock_state_sequencer_tb;
  import conv_seq_pkg::*;
  localparam logic [POR_W-1:0] POR_T = 19'd50;
  localparam logic [DET_W-1:0] DET_T = 14'd100;
  // shortened conversion keeps the run to a few tens of thousands of cycles
  localparam logic [15:0] CONV_T = 16'h07D0;
  localparam int CONV_CYC = CONV_T * 4;
  localparam int TIMEOUT = 40000;
  localparam logic [31:0] WORD_EXP = {8'h00, 3'b000, RES, 4'h0};
  localparam logic [RESULT_W-1:0] RES = 17'h1A5C3;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pin_in_t pins;
  serial_out_t ser;
  seq_status_t st;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  int t0;
  logic [31:0] w;

  always #5 core_clk_i = ~core_clk_i;

  conv_sequencer #(.CONV_LEN(CONV_T), .POR_CYC(POR_T), .DET_CYC(DET_T)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
    .conv_result_i(RES), .serial_o(ser), .status_o(st));

  host_model host (.core_clk_i(core_clk_i), .serial_i(ser), .pins_o(pins));

  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard: the run needs just over three shortened conversions
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
      num_errors++;
    end
  endtask

  // settle after the edge before sampling outputs
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge core_clk_i);
    #2;
  endtask

  task automatic wait_state(input seq_state_t s, input int lim);
    int n;
    n = 0;
    while (st.state !== s && n < lim) begin
      wait_cyc(1);
      n++;
    end
  endtask

  task automatic t_por();
    wait_cyc(3);
    chk("por state", ST_POR, st.state);
    chk("por flag", 1, st.por_active);
    chk("por sdo_oe_n", 1, ser.sdo_oe_n);
    chk("por sck_oe_n", 1, ser.sck_oe_n);
    host.rej_on = 1'b1;
    @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    t0 = cycles;
    wait_state(ST_CONVERT, 1000);
    chk("por length ok", 1, (cycles - t0) inside {[POR_T-2:POR_T+3]});
    chk("after por", ST_CONVERT, st.state);
  endtask

  task automatic t_convert();
    t0 = cycles;
    wait_cyc(20);
    chk("ext_sel", 1, st.ext_sel);
    chk("osc_en", 0, st.osc_en);
    host.set_cs(1'b0);
    wait_cyc(8);
    chk("eoc in convert", 1, ser.sdo);
    host.read_bits(4, w);
    chk("clocks in convert", ST_CONVERT, st.state);
    host.set_cs(1'b1);
    wait_state(ST_SLEEP, CONV_CYC + 2000);
    chk("conv len ok", 1, (cycles - t0) inside {[CONV_CYC-16:CONV_CYC+16]});
    wait_cyc(200);
    chk("sleep cs high", ST_SLEEP, st.state);
  endtask

  task automatic t_read();
    host.set_cs(1'b0);
    wait_cyc(8);
    chk("eoc sleep", 0, ser.sdo);
    chk("sleep before sck", ST_SLEEP, st.state);
    host.read_bits(24, w);
    chk("word", WORD_EXP, w);
    wait_cyc(6);
    chk("after 24th", ST_CONVERT, st.state);
    chk("eoc new conv", 1, ser.sdo);
    host.read_bits(8, w);
    chk("extra clocks", 32'hFF, w);
    host.set_cs(1'b1);
    wait_cyc(8);
    chk("sdo released", 1, ser.sdo_oe_n);
  endtask

  // sck left high at select fall: device clocks the word out itself
  task automatic t_internal();
    wait_state(ST_SLEEP, CONV_CYC + 2000);
    @(posedge core_clk_i);
    #1 host.sck_drv = 1'b1;
    host.set_cs(1'b0);
    wait_state(ST_DOUT, 20);
    t0 = cycles;
    chk("int dout", ST_DOUT, st.state);
    host.read_int(w);
    chk("int word", WORD_EXP, w);
    wait_state(ST_CONVERT, 100);
    chk("int len ok", 1, (cycles - t0) inside {[760:776]});
    chk("int sck low", 0, ser.sck);
    host.set_cs(1'b1);
    @(posedge core_clk_i);
    #1 host.sck_drv = 1'b0;
  endtask

  // select pulled high after five bits cuts the readout short
  task automatic t_abort();
    wait_state(ST_SLEEP, CONV_CYC + 2000);
    host.set_cs(1'b0);
    host.read_bits(5, w);
    chk("abort bits", {27'h0, 3'b000, RES[16:15]}, w);
    chk("mid read", ST_DOUT, st.state);
    host.set_cs(1'b1);
    wait_cyc(6);
    chk("abort state", ST_CONVERT, st.state);
    chk("abort eoc", 1, ser.sdo);
  endtask

  // conversion clock vanishes mid-conversion, then pin held static high
  task automatic t_lost();
    host.rej_on = 1'b0;
    t0 = cycles;
    while (st.ext_sel !== 1'b0 && cycles - t0 < DET_T + 40) wait_cyc(1);
    chk("loss not early", 1, (cycles - t0) >= DET_T - 10);
    chk("osc back", 1, st.osc_en);
    chk("ext off", 0, st.ext_sel);
    chk("suspect", 1, st.suspect);
    host.rej_lvl = 1'b1;
    wait_cyc(3 * DET_T);
    chk("static high", 0, st.ext_sel);
    chk("still convert", ST_CONVERT, st.state);
  endtask

  initial begin
    t_por();
    t_convert();
    t_read();
    t_internal();
    t_abort();
    t_lost();
    results();
  end
endmodule // conversion_clock_state_sequencer_tb
